// ==== src/edm_monitor_prbs.sv ====
// DS0 monitor and 2^15-1 pattern generator/checker of one E1 framer.
// Assumes framer supplies one-clk bit strobes with a first-bit-of-frame flag
// for each direction, all synchronous to clk.
//
// Summary of operation
// R1 - One transmit and one receive 64 kbps channel are monitored at once.
// R2 - Transmit channel selector is control_3 bits 4..0, bit 4 most significant.
// R3 - Receive channel selector is control_4 bits 4..0, bit 4 most significant.
// R4 - Software loads each selector with the plain binary channel number.
// R5 - Transmit snapshot at 0x22; bit 7 first transmitted, bit 0 last.
// R6 - Receive snapshot at 0x2A; bit 7 first received, bit 0 last.
// R7 - Generator and checker use the 2^15-1 maximal-length sequence.
// R8 - control_5 bits 3..2: off, single slot, slots 1-31, unframed for transmit.
// R9 - control_5 bits 1..0: off, single slot, slots 1-31, unframed for receive.
// R10 - In single-slot mode the channel selectors choose the pattern slot.
// R11 - Unframed uses all 256 bits; framed leaves slot 0 untouched.
// R12 - status_2 bit 0 is set while the checker is synchronised.
// R13 - Sync holds until six or more errors fall in 64 bits.
// R14 - Any receive pattern mode turns the far-end counter into error counter.
// R15 - Enabled user outputs pulse once per bit error after sync.
// R16 - Pattern errors are counted only while the checker is synchronised.
// R17 - Fifteen-stage register, taps 15 and 14; checker seeds from received bits.
// R18 - Snapshots update once per frame with whole octets only.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "edm_map.svh"
module edm_monitor_prbs (
    input wire logic clk,
    input wire logic resetn,
    input edm_pkg::edm_bus_req_s bus_req,
    output logic [7:0] bus_rdata,
    input edm_pkg::edm_bit_s tx_bit,
    output logic tx_line_bit,
    input edm_pkg::edm_bit_s rx_bit,
    input wire logic ebit_zero,
    input wire logic framer_in_sync,
    output logic user_output_a,
    output logic user_output_b
);
    import edm_pkg::*;

    // ======================================================================
    // Declarations
    edm_top_s q, d;
    edm_mode_e tx_mode;
    edm_mode_e rx_mode;
    logic [4:0] tx_sel;
    logic [4:0] rx_sel;
    logic [7:0] tx_cur;
    logic [7:0] rx_cur;
    logic tx_ins;
    logic rx_pat;
    logic tx_bit_out;
    logic tx_mon_done;
    logic rx_mon_done;
    logic cnt_evt;
    logic chk_sync;
    logic chk_err;

    // Position of a bit within its frame, restarted by the first-bit flag
    function automatic logic [7:0] edm_bit_pos(input edm_bit_s b, input logic [7:0] pos);
        return b.first ? `EDM_POS_ZERO : pos;
    endfunction

    // Completion of the monitored octet: last bit of the selected slot
    function automatic logic edm_oct_done(input logic [7:0] pos, input logic [4:0] sel);
        return (pos[7:3] == sel) && (pos[2:0] == `EDM_LAST_BIT);
    endfunction

    // ======================================================================
    // Mode and selector decode
    // Selectors are taken as the plain channel number; no decimal remapping
    assign tx_sel = q.ctl3[`EDM_SEL_MSB:0]; // R2 R4
    assign rx_sel = q.ctl4[`EDM_SEL_MSB:0]; // R3 R4
    assign tx_mode = edm_mode_e'(q.ctl5[`EDM_TXMODE_HI:`EDM_TXMODE_LO]); // R8
    assign rx_mode = edm_mode_e'(q.ctl5[`EDM_RXMODE_HI:`EDM_RXMODE_LO]); // R9

    // Current bit position in each direction
    assign tx_cur = edm_bit_pos(tx_bit, q.tx_pos);
    assign rx_cur = edm_bit_pos(rx_bit, q.rx_pos);

    // Pattern slot decisions; in single-slot mode the selector picks the slot
    assign tx_ins = edm_pat_slot(tx_mode, tx_cur[7:3], tx_sel); // R10 R11
    assign rx_pat = edm_pat_slot(rx_mode, rx_cur[7:3], rx_sel); // R10 R11

    // Transmitted bit: pattern or framer data
    assign tx_bit_out = tx_ins ? edm_prbs_fb(q.tx_lfsr) : tx_bit.data; // R7

    // Octet completion for both monitors, each on its own selector
    assign tx_mon_done = tx_bit.en && edm_oct_done(tx_cur, tx_sel); // R1
    assign rx_mon_done = rx_bit.en && edm_oct_done(rx_cur, rx_sel); // R1

    // Counter source: pattern errors in any receive mode, else far-end errors
    // Checker errors only rise in sync; the error that drops sync still counts
    assign cnt_evt = (rx_mode != EDM_MODE_OFF) ? chk_err
                                               : (ebit_zero && framer_in_sync); // R14 R16

    // ======================================================================
    // Receive pattern checker
    edm_prbs_chk u_chk (
        .clk(clk),
        .resetn(resetn),
        .active(rx_mode != EDM_MODE_OFF),
        .bit_en(rx_bit.en && rx_pat),
        .bit_in(rx_bit.data),
        .sync(chk_sync),
        .err_pulse(chk_err)
    );

    // ======================================================================
    // Next state of the whole block
    always_comb begin
        d = q;
        d.rdata = `EDM_BYTE_ZERO;

        // Host writes; snapshots, status and counter are read-only
        if (bus_req.wr) begin
            case (bus_req.addr)
                `EDM_OFF_CTL3: d.ctl3 = bus_req.wdata; // R2
                `EDM_OFF_CTL4: d.ctl4 = bus_req.wdata; // R3
                `EDM_OFF_CTL5: d.ctl5 = bus_req.wdata; // R8 R9
                default: d.ctl3 = q.ctl3;
            endcase
        end

        // Host reads; data stands one cycle, unmapped reads return zero
        if (bus_req.rd) begin
            case (bus_req.addr)
                `EDM_OFF_ERR_HI: d.rdata = q.err_cnt[15:8];
                `EDM_OFF_ERR_LO: d.rdata = q.err_cnt[7:0];
                `EDM_OFF_CTL3: d.rdata = q.ctl3;
                `EDM_OFF_CTL4: d.rdata = q.ctl4;
                `EDM_OFF_CTL5: d.rdata = q.ctl5;
                `EDM_OFF_STATUS2: d.rdata = {7'h00, chk_sync}; // R12
                `EDM_OFF_TX_SNAP: d.rdata = q.tx_snap; // R5
                `EDM_OFF_RX_SNAP: d.rdata = q.rx_snap; // R6
                default: d.rdata = `EDM_BYTE_ZERO;
            endcase
        end

        // Transmit path: insert pattern, advance generator, monitor octet
        if (tx_bit.en) begin
            d.tx_pos = 8'(tx_cur + `EDM_POS_ONE);
            d.tx_out = tx_bit_out; // R8 R11
            if (tx_ins) begin
                // Generator advances only on bits it fills, so slots stay contiguous
                d.tx_lfsr = {q.tx_lfsr[13:0], edm_prbs_fb(q.tx_lfsr)}; // R7 R17
            end
            d.tx_shift = {q.tx_shift[5:0], tx_bit_out};
            if (tx_mon_done) begin
                // Whole octet loads at once, so a read never mixes two frames
                d.tx_snap = {q.tx_shift, tx_bit_out}; // R5 R18
            end
        end

        // Receive path: monitor octet of the selected channel
        if (rx_bit.en) begin
            d.rx_pos = 8'(rx_cur + `EDM_POS_ONE);
            d.rx_shift = {q.rx_shift[5:0], rx_bit.data};
            if (rx_mon_done) begin
                d.rx_snap = {q.rx_shift, rx_bit.data}; // R6 R18
            end
        end

        // Error counter saturates rather than wrap, so long runs stay readable
        if (cnt_evt && q.err_cnt != `EDM_CNT_MAX) begin
            d.err_cnt = 16'(q.err_cnt + `EDM_CNT_ONE); // R14 R16
        end

        // Bit error pulses on the user outputs, one clk per error
        d.out_a = chk_err && q.ctl5[`EDM_USER_OUTPUT_A_EN]; // R15
        d.out_b = chk_err && q.ctl5[`EDM_USER_OUTPUT_B_EN]; // R15
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '{ctl3: `EDM_CTL_RST, ctl4: `EDM_CTL_RST, ctl5: `EDM_CTL_RST,
                   rdata: `EDM_BYTE_ZERO, tx_pos: `EDM_POS_ZERO, tx_shift: 7'h00,
                   tx_snap: `EDM_BYTE_ZERO, tx_lfsr: `EDM_PRBS_SEED, tx_out: 1'b0,
                   rx_pos: `EDM_POS_ZERO, rx_shift: 7'h00, rx_snap: `EDM_BYTE_ZERO,
                   err_cnt: 16'h0000, out_a: 1'b0, out_b: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign bus_rdata = q.rdata;
    assign tx_line_bit = q.tx_out;
    assign user_output_a = q.out_a;
    assign user_output_b = q.out_b;

    // ======================================================================
    // Checks
    default clocking edm_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Control write lands in the selector
    sel_write_a: assert property (
        (bus_req.wr && bus_req.addr == `EDM_OFF_CTL3) |=> q.ctl3 == $past(bus_req.wdata))
        else $error("transmit selector write lost"); // R2

    rx_sel_write_a: assert property (
        (bus_req.wr && bus_req.addr == `EDM_OFF_CTL4) |=> rx_sel == $past(bus_req.wdata[4:0]))
        else $error("receive selector write lost"); // R3

    // Disabled mode passes framer data untouched
    tx_pass_a: assert property (
        (tx_bit.en && tx_mode == EDM_MODE_OFF) |=> tx_line_bit == $past(tx_bit.data))
        else $error("transmit data altered with pattern off"); // R8

    // Framed mode leaves the alignment slot intact
    fas_intact_a: assert property (
        (tx_bit.en && tx_mode == EDM_MODE_FRAMED && tx_cur[7:3] == `EDM_FAS_SLOT)
        |=> tx_line_bit == $past(tx_bit.data))
        else $error("framed pattern overwrote slot 0"); // R11

    // Unframed mode puts the generator on every bit
    unframed_gen_a: assert property (
        (tx_bit.en && tx_mode == EDM_MODE_UNFRAMED)
        |=> tx_line_bit == $past(q.tx_lfsr[14] ^ q.tx_lfsr[13]))
        else $error("unframed bit not from generator"); // R7 R11

    // Transmit snapshot last bit matches the bit just sent
    tx_snap_a: assert property ($past(tx_mon_done) |-> q.tx_snap[0] == tx_line_bit)
        else $error("transmit snapshot last bit wrong"); // R5

    // Snapshots move only on a finished octet
    snap_hold_a: assert property (
        !tx_mon_done && !rx_mon_done |=> $stable(q.tx_snap) && $stable(q.rx_snap))
        else $error("snapshot changed mid octet"); // R18

    // Receive snapshot is shift history then last bit
    rx_snap_a: assert property (
        rx_mon_done |=> q.rx_snap == {$past(q.rx_shift), $past(rx_bit.data)})
        else $error("receive snapshot wrong"); // R6

    // Status read reflects checker sync
    status_rd_a: assert property (
        (bus_req.rd && bus_req.addr == `EDM_OFF_STATUS2) |=> bus_rdata[0] == $past(chk_sync))
        else $error("status sync bit wrong"); // R12

    // Pattern errors counted only while synchronised
    cnt_gate_a: assert property (
        (rx_mode != EDM_MODE_OFF && q.err_cnt != $past(q.err_cnt)) |-> $past(chk_err))
        else $error("counter moved without pattern error"); // R14 R16

    cnt_step_a: assert property (
        (rx_mode != EDM_MODE_OFF && chk_err && q.err_cnt != `EDM_CNT_MAX)
        |=> q.err_cnt == 16'($past(q.err_cnt) + `EDM_CNT_ONE))
        else $error("pattern error not counted"); // R14

    // User output pulse follows a checker error by one clk
    out_pulse_a: assert property (
        (chk_err && q.ctl5[`EDM_USER_OUTPUT_A_EN]) |=> user_output_a)
        else $error("user output pulse missing"); // R15

    out_cause_a: assert property (user_output_b |-> $past(chk_err) && $past(q.ctl5[`EDM_USER_OUTPUT_B_EN]))
        else $error("user output b without error"); // R15

endmodule

// ==== src/edm_map.svh ====
// Address map, field positions, reset values and counts of the DS0 monitor
// and pattern test block. Definitions only; included by package and modules.
`ifndef EDM_MAP_SVH
`define EDM_MAP_SVH

// ==========================================================================
// Register offsets (8-bit host port)
`define EDM_OFF_ERR_HI 8'h04
`define EDM_OFF_ERR_LO 8'h05
`define EDM_OFF_CTL3 8'h14
`define EDM_OFF_CTL4 8'h15
`define EDM_OFF_STATUS2 8'h18
`define EDM_OFF_CTL5 8'h19
`define EDM_OFF_TX_SNAP 8'h22
`define EDM_OFF_RX_SNAP 8'h2A

// ==========================================================================
// Field positions
`define EDM_SEL_MSB 4
`define EDM_TXMODE_HI 3
`define EDM_TXMODE_LO 2
`define EDM_RXMODE_HI 1
`define EDM_RXMODE_LO 0
`define EDM_USER_OUTPUT_A_EN 4
`define EDM_USER_OUTPUT_B_EN 5
`define EDM_SYNC_BIT 0

// ==========================================================================
// Reset values and constants
`define EDM_CTL_RST 8'h00
`define EDM_BYTE_ZERO 8'h00
`define EDM_POS_ZERO 8'h00
`define EDM_POS_ONE 8'h01
`define EDM_LAST_BIT 3'h7
`define EDM_FAS_SLOT 5'h00
`define EDM_PRBS_SEED 15'h7FFF
`define EDM_PRBS_ZERO 15'h0000
`define EDM_ERR_WIN 64
`define EDM_ERR_LIMIT 7'h06
`define EDM_SYNC_RUN 6'h20
`define EDM_RUN_ONE 6'h01
`define EDM_ERRS_ZERO 7'h00
`define EDM_CNT_ONE 16'h0001
`define EDM_CNT_MAX 16'hFFFF

`endif

// ==== src/edm_pkg.sv ====
// Types and shared functions of the DS0 monitor and pattern test block.
// Assumes edm_map.svh is on the include path.
`include "edm_map.svh"
package edm_pkg;

    // ======================================================================
    // Modes and states
    typedef enum logic [1:0] {
        EDM_MODE_OFF,
        EDM_MODE_SLOT,
        EDM_MODE_FRAMED,
        EDM_MODE_UNFRAMED
    } edm_mode_e;

    typedef enum logic [1:0] {
        EDM_CHK_IDLE,
        EDM_CHK_HUNT,
        EDM_CHK_SYNC
    } edm_chk_e;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } edm_bus_req_s;

    typedef struct packed {
        logic en;
        logic first;
        logic data;
    } edm_bit_s;

    // ======================================================================
    // State of the checker and of the top
    typedef struct packed {
        edm_chk_e state;
        logic [14:0] lfsr;
        logic [5:0] run;
        logic [`EDM_ERR_WIN-1:0] hist;
        logic [6:0] errs;
        logic err_pulse;
        logic sync;
    } edm_chk_s;

    typedef struct packed {
        logic [7:0] ctl3;
        logic [7:0] ctl4;
        logic [7:0] ctl5;
        logic [7:0] rdata;
        logic [7:0] tx_pos;
        logic [6:0] tx_shift;
        logic [7:0] tx_snap;
        logic [14:0] tx_lfsr;
        logic tx_out;
        logic [7:0] rx_pos;
        logic [6:0] rx_shift;
        logic [7:0] rx_snap;
        logic [15:0] err_cnt;
        logic out_a;
        logic out_b;
    } edm_top_s;

    // ======================================================================
    // Shared functions
    // Feedback of x^15 + x^14 + 1, taps at stages 15 and 14
    function automatic logic edm_prbs_fb(input logic [14:0] lfsr);
        return lfsr[14] ^ lfsr[13];
    endfunction

    // Whether a time slot carries the pattern in a given mode
    function automatic logic edm_pat_slot(input edm_mode_e mode, input logic [4:0] slot,
                                          input logic [4:0] sel);
        logic hit;
        hit = 1'b0;
        case (mode)
            EDM_MODE_SLOT: hit = (slot == sel);
            EDM_MODE_FRAMED: hit = (slot != `EDM_FAS_SLOT);
            EDM_MODE_UNFRAMED: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

endpackage

// ==== src/edm_prbs_chk.sv ====
// Receive pattern checker: self-seeding hunt, sync hold and error window.
// Assumes bit_en marks each pattern-carrying received bit, one clk wide.
`timescale 1ns/10ps
`include "edm_map.svh"
module edm_prbs_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic active,
    input wire logic bit_en,
    input wire logic bit_in,
    output logic sync,
    output logic err_pulse
);
    import edm_pkg::*;

    edm_chk_s q, d;
    logic pred;
    logic err;
    logic [6:0] errs_nx;

    // ======================================================================
    // Next state
    always_comb begin
        d = q;
        d.err_pulse = 1'b0;
        pred = edm_prbs_fb(q.lfsr); // R7 R17
        err = bit_in ^ pred;
        errs_nx = 7'(q.errs + {6'h00, err} - {6'h00, q.hist[`EDM_ERR_WIN-1]});
        if (!active) begin
            d.state = EDM_CHK_IDLE;
            d.sync = 1'b0;
            d.run = 6'h00;
            d.errs = `EDM_ERRS_ZERO;
            d.hist = '0;
        end else if (bit_en) begin
            case (q.state)
                EDM_CHK_IDLE: begin
                    d.lfsr = {q.lfsr[13:0], bit_in};
                    d.state = EDM_CHK_HUNT;
                end
                EDM_CHK_HUNT: begin
                    // Seed from the line; an all-zero register would lock on silence
                    d.lfsr = {q.lfsr[13:0], bit_in}; // R17
                    if (!err && q.lfsr != `EDM_PRBS_ZERO) begin
                        d.run = 6'(q.run + `EDM_RUN_ONE);
                        if (q.run == 6'(`EDM_SYNC_RUN - `EDM_RUN_ONE)) begin
                            d.state = EDM_CHK_SYNC;
                            d.sync = 1'b1;
                            d.hist = '0;
                            d.errs = `EDM_ERRS_ZERO;
                        end
                    end else begin
                        d.run = 6'h00;
                    end
                end
                EDM_CHK_SYNC: begin
                    // Free-running once locked, so errors do not corrupt the reference
                    d.lfsr = {q.lfsr[13:0], pred};
                    d.hist = {q.hist[`EDM_ERR_WIN-2:0], err};
                    d.errs = errs_nx;
                    d.err_pulse = err; // R15
                    if (errs_nx >= `EDM_ERR_LIMIT) begin
                        d.state = EDM_CHK_HUNT; // R13
                        d.sync = 1'b0;
                        d.run = 6'h00;
                    end
                end
                default: d.state = EDM_CHK_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '{state: EDM_CHK_IDLE, lfsr: `EDM_PRBS_ZERO, run: 6'h00, hist: '0,
                   errs: `EDM_ERRS_ZERO, err_pulse: 1'b0, sync: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign sync = q.sync;
    assign err_pulse = q.err_pulse;

    // ======================================================================
    // Checks
    win_limit_a: assert property (@(posedge clk) disable iff (!resetn)
        q.sync |-> q.errs < `EDM_ERR_LIMIT) else $error("sync held past error limit"); // R13
    err_sync_a: assert property (@(posedge clk) disable iff (!resetn)
        q.err_pulse |-> $past(q.sync)) else $error("error pulse before sync"); // R15
    drop_sync_a: assert property (@(posedge clk) disable iff (!resetn)
        (active && bit_en && q.sync && err && errs_nx >= `EDM_ERR_LIMIT) |=> !q.sync)
        else $error("sync not dropped on error burst"); // R13

endmodule

// ==== tb/edm_line_model.sv ====
// Far-end E1 line: one bit strobe every four clocks, 256 bits a frame.
// Assumes clk of the block; the bench holds resetn low to keep the line quiet.
`timescale 1ns/10ps
module edm_line_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pat_on,
    input wire logic inj_err,
    output edm_pkg::edm_bit_s bit_o,
    output logic [7:0] pos
);
    import edm_pkg::*;
    logic [1:0] div_q;
    logic [14:0] lfsr_q;
    logic [7:0] np;
    logic [7:0] oct;
    logic fb;
    // Next position, slot octet {101,slot} and pattern feedback taps 15/14
    assign np = pos + 8'h01;
    assign oct = {3'h5, np[7:3]};
    assign fb = lfsr_q[14] ^ lfsr_q[13];
    // ======================================================================
    // Strobe generator; an idle data line toggles so no stale bit lingers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_q <= 2'h0;
            pos <= 8'hFF;
            lfsr_q <= 15'h7FFF;
            bit_o <= '0;
        end else begin
            div_q <= div_q + 2'h1;
            bit_o.en <= (div_q == 2'h3);
            bit_o.data <= ~bit_o.data;
            if (div_q == 2'h3) begin
                pos <= np;
                bit_o.first <= (np == 8'h00);
                // First bit of a slot goes out as bit 7
                bit_o.data <= pat_on ? (fb ^ inj_err) : oct[3'h7 - np[2:0]];
                if (pat_on) begin
                    lfsr_q <= {lfsr_q[13:0], fb};
                end
            end
        end
    end
endmodule

// ==== tb/tb_edm_monitor_prbs.sv ====
// Self-checking bench of edm_monitor_prbs with two line models.
// Assumes src/ package and map header compiled first.
`timescale 1ns/10ps
`include "edm_map.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module tb_edm_monitor_prbs;
    import edm_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e;} edm_row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic line_on = 1'b0;
    logic pat_on = 1'b0;
    logic inj = 1'b0;
    logic insync = 1'b1;
    logic chk_un = 1'b0;
    logic chk_fr = 1'b0;
    logic chk_ts = 1'b0;
    logic en_d = 1'b0;
    logic dat_d = 1'b0;
    logic s0_d = 1'b0;
    logic [14:0] hist = '0;
    logic [7:0] tx_pos;
    logic [7:0] v;
    int nbits = 0;
    int pa = 0;
    int pb = 0;
    int err_total = 0;
    int checked = 0;
    edm_bus_req_s bus_req = '0;
    edm_bit_s tx_bit;
    edm_bit_s rx_bit;
    logic [7:0] bus_rdata;
    logic tx_line_bit;
    logic user_output_a;
    logic user_output_b;
    edm_row_s rows[13] = '{'{8'h04, 8'h00, 0, 8'h00}, '{8'h05, 8'h00, 0, 8'h00},
        '{8'h14, 8'h00, 0, 8'h00}, '{8'h15, 8'h00, 0, 8'h00}, '{8'h18, 8'h00, 0, 8'h00},
        '{8'h19, 8'h00, 0, 8'h00}, '{8'h22, 8'h00, 0, 8'h00}, '{8'h2A, 8'h00, 0, 8'h00},
        '{8'h14, 8'h06, 1, 8'h06}, '{8'h15, 8'h0F, 1, 8'h0F}, '{8'h22, 8'h55, 1, 8'h00},
        '{8'h18, 8'h55, 1, 8'h00}, '{8'h30, 8'h55, 1, 8'h00}};
    always #12.5 clk = ~clk;
    edm_monitor_prbs edm_monitor_prbs_inst (.clk(clk), .resetn(resetn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .tx_bit(tx_bit), .tx_line_bit(tx_line_bit), .rx_bit(rx_bit),
        .ebit_zero(inj), .framer_in_sync(insync), .user_output_a(user_output_a),
        .user_output_b(user_output_b));
    edm_line_model tx_model_inst (.clk(clk), .resetn(line_on), .pat_on(1'b0),
        .inj_err(1'b0), .bit_o(tx_bit), .pos(tx_pos));
    edm_line_model rx_model_inst (.clk(clk), .resetn(line_on), .pat_on(pat_on),
        .inj_err(inj), .bit_o(rx_bit), .pos());
    // ======================================================================
    // Line watch: tx bit lands one clock after its strobe
    always @(posedge clk) begin
        en_d <= tx_bit.en;
        dat_d <= tx_bit.data;
        s0_d <= (tx_pos < 8'h08) || (chk_ts && tx_pos[7:3] != 5'h06);
        pa <= pa + int'(user_output_a);
        pb <= pb + int'(user_output_b);
        if (en_d) begin
            hist <= {hist[13:0], tx_line_bit};
            nbits <= chk_un ? nbits + 1 : 0;
            if (chk_un && nbits > 16) `CHK("tx pattern", hist[14] ^ hist[13], tx_line_bit)
            if (chk_fr && s0_d) `CHK("tx bypass", dat_d, tx_line_bit)
        end
    end
    // ======================================================================
    // Bus cycles: strobe for one clock, read data in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1 d = bus_rdata;
    endtask
    // One inverted line bit, four clocks cover exactly one strobe
    task automatic inject();
        @(posedge clk);
        inj <= 1'b1;
        repeat (4) @(posedge clk);
        inj <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        wrap_up();
    end
    // ======================================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            `CHK("register", rows[i].e, v)
        end
        // Monitors: tx slot 6, rx slot 15, octet {101,slot}
        line_on <= 1'b1;
        repeat (3000) @(posedge clk);
        rd(`EDM_OFF_TX_SNAP, v);
        `CHK("tx snapshot", 8'hA6, v)
        rd(`EDM_OFF_RX_SNAP, v);
        `CHK("rx snapshot", 8'hAF, v)
        // Unframed pattern both ways, both user outputs on
        pat_on <= 1'b1;
        wr(`EDM_OFF_CTL5, 8'h3F);
        repeat (40) @(posedge clk);
        chk_un <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            rd(`EDM_OFF_STATUS2, v);
            if (v === 8'h01) break;
            repeat (20) @(posedge clk);
        end
        `CHK("sync", 8'h01, v)
        if (v !== 8'h01) wrap_up();
        rd(`EDM_OFF_ERR_LO, v);
        `CHK("count before error", 8'h00, v)
        inject();
        repeat (40) @(posedge clk);
        `CHK("pulses a", 1, pa)
        `CHK("pulses b", 1, pb)
        rd(`EDM_OFF_ERR_HI, v);
        `CHK("count hi", 8'h00, v)
        rd(`EDM_OFF_ERR_LO, v);
        `CHK("count lo", 8'h01, v)
        repeat (6) inject();
        repeat (40) @(posedge clk);
        rd(`EDM_OFF_STATUS2, v);
        `CHK("sync lost", 8'h00, v)
        rd(`EDM_OFF_ERR_LO, v);
        `CHK("count at drop", 8'h06, v)
        // Framed tx: slot 0 passes the framer bits
        chk_un <= 1'b0;
        wr(`EDM_OFF_CTL5, 8'h08);
        chk_fr <= 1'b1;
        repeat (1100) @(posedge clk);
        // Single slot: only slot 6 carries the pattern, all else passes
        wr(`EDM_OFF_CTL5, 8'h04);
        chk_ts <= 1'b1;
        repeat (1100) @(posedge clk);
        chk_fr <= 1'b0;
        chk_ts <= 1'b0;
        // Receive off: far-end events count only with framer sync
        inj <= 1'b1;
        @(posedge clk);
        inj <= 1'b0;
        insync <= 1'b0;
        @(posedge clk);
        inj <= 1'b1;
        @(posedge clk);
        inj <= 1'b0;
        rd(`EDM_OFF_ERR_LO, v);
        `CHK("far-end count", 8'h07, v)
        // Reset in mid-run clears control and count; line held quiet with it
        @(posedge clk);
        resetn <= 1'b0;
        line_on <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        line_on <= 1'b1;
        @(posedge clk);
        `CHK("line bit after reset", 1'b0, tx_line_bit)
        rd(`EDM_OFF_CTL5, v);
        `CHK("control_5 after reset", 8'h00, v)
        rd(`EDM_OFF_ERR_LO, v);
        `CHK("count after reset", 8'h00, v)
        wrap_up();
    end
endmodule
